// ==== src/imr_pkg.sv ====
// Purpose: Shared constants and types for the two-wire master receiver.
// Assumes: 125 MHz system clock, registers on a 32-bit Avalon-MM slave.
// Notes:   Register offsets are byte addresses, one aligned word each.
package imr_pkg;

	localparam logic [3:0] OFS_CTRL  = 4'h0;
	localparam logic [3:0] OFS_STATE = 4'h4;
	localparam logic [3:0] OFS_BUF   = 4'h8;

	localparam logic [7:0] ST_BERR     = 8'h00;
	localparam logic [7:0] ST_START    = 8'h08;
	localparam logic [7:0] ST_RSTART   = 8'h10;
	localparam logic [7:0] ST_AW_ACK   = 8'h18;
	localparam logic [7:0] ST_AW_NACK  = 8'h20;
	localparam logic [7:0] ST_LOST     = 8'h38;
	localparam logic [7:0] ST_AR_ACK   = 8'h40;
	localparam logic [7:0] ST_AR_NACK  = 8'h48;
	localparam logic [7:0] ST_RX_ACK   = 8'h50;
	localparam logic [7:0] ST_RX_NACK  = 8'h58;
	localparam logic [7:0] ST_NO_INFO  = 8'hf8;

	localparam logic [9:0] DIV_CODE0 = 10'h100;
	localparam logic [9:0] DIV_CODE1 = 10'h0f4;
	localparam logic [9:0] DIV_CODE2 = 10'h0c0;
	localparam logic [9:0] DIV_CODE3 = 10'h0a0;
	localparam logic [9:0] DIV_CODE4 = 10'h3c0;
	localparam logic [9:0] DIV_CODE5 = 10'h078;
	localparam logic [9:0] DIV_CODE6 = 10'h03c;

	localparam logic [3:0] LAST_BIT  = 4'h8;
	localparam logic [7:0] CTRL_RST  = 8'h00;
	localparam logic [7:0] BUF_RST   = 8'h00;

	typedef struct packed {
		logic cr2;
		logic ens;
		logic start_request_flag;
		logic stop_request_flag;
		logic si;
		logic aa;
		logic cr1;
		logic cr0;
	} imr_ctrl_t;

	typedef enum logic [7:0] {
		S_IDLE  = 8'h01,
		S_START = 8'h02,
		S_HOLD  = 8'h04,
		S_BITS  = 8'h08,
		S_STOP  = 8'h10,
		S_RST   = 8'h20,
		S_LOSTW = 8'h40,
		S_BERR  = 8'h80
	} imr_state_t;

	typedef enum logic [2:0] {
		PH_LOW  = 3'h1,
		PH_WAIT = 3'h2,
		PH_HIGH = 3'h4
	} imr_phase_t;

endpackage

// ==== src/imr_master_rx.sv ====
// Purpose: Two-wire bus master receiver with arbitration and bus-error recovery.
// Assumes: Pull-ups on both lines; software polls the service flag.
// Notes:   Avalon-MM slave answers every access one cycle after it is seen.
//
// How it works
// R1 - Enabled start request waits idle, sends START
// R2 - After read address, raise flag, then receive
// R3 - START reports 0x08; buffer byte sent next
// R4 - Repeated START 0x10; write address selects transmit
// R5 - Arbitration loss gives 0x38, release or restart
// R6 - 0x40/0x50 receive next; ack per ack-assert
// R7 - Not-acked states plus start give repeated START
// R8 - Not-acked states plus stop send STOP, clear
// R9 - Both requests send STOP then new START
// R10 - Software reads received byte while answering status
// R11 - Released SDA read low loses arbitration
// R12 - Loser stops driving, acts as receiver (code releases both lines and waits in S_LOSTW, sampling no further bits)
// R13 - Arbitration continues bit by bit across bytes
// R14 - Clock generated only in master mode
// R15 - SCL rate is clock over selected factor
// R16 - Wait for released SCL before high period
// R17 - START/STOP inside a bit is bus error
// R18 - Stop plus flag clear leaves bus error
// R19 - Bus-error exit releases lines without STOP
// R20 - Rate codes divide by 256..60, 111 reserved
// R21 - Every state but 0xF8 raises service flag
// R22 - Lines only pulled low or released
//
// The Avalon-MM register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module imr_master_rx
	import imr_pkg::*;
#(
	parameter int ADDR_W = 4
) (
	input  wire logic              clk_sys_i,
	input  wire logic              rstn_i,
	input  wire logic [ADDR_W-1:0] avs_address_i,
	input  wire logic              avs_read_i,
	input  wire logic              avs_write_i,
	input  wire logic [31:0]       avs_writedata_i,
	input  wire logic [3:0]        avs_byteenable_i,
	output logic      [31:0]       avs_readdata_o,
	output logic                   avs_waitrequest_o,
	input  wire logic              scl_i,
	output logic                   scl_o,
	output logic                   scl_oe_o,
	input  wire logic              sda_i,
	output logic                   sda_o,
	output logic                   sda_oe_o,
	output logic                   master_transmit_mode_o
);

	if (ADDR_W < 4) begin : g_chk
		$error("ADDR_W must be at least 4");
	end

	imr_ctrl_t  ctrl_r;
	imr_state_t st_r;
	imr_phase_t ph_r;
	logic [7:0] state_code_r;
	logic [7:0] byte_buffer_r;
	logic [7:0] sh_r;
	logic [3:0] bit_r;
	logic [8:0] cnt_r;
	logic [8:0] half_r;
	logic       rx_r;
	logic       addr_r;
	logic       rd_r;
	logic       ack_sel_r;
	logic       ack_in_r;
	logic       rep_r;
	logic       busy_r;
	logic       scl_oe_r;
	logic       sda_oe_r;
	logic       mtx_r;
	logic       wait_r;
	logic [31:0] rdata_r;
	logic       scl_m_r, scl_s_r, scl_d_r;
	logic       sda_m_r, sda_s_r, sda_d_r;

	logic       acc;
	logic       wr_ctrl;
	logic       wr_buf;
	logic       fin;
	logic       i_send;
	imr_ctrl_t  wd;

	assign acc     = (avs_read_i || avs_write_i) && wait_r;
	assign wr_ctrl = avs_write_i && acc && avs_address_i[3:0] == OFS_CTRL && avs_byteenable_i[0];
	assign wr_buf  = avs_write_i && acc && avs_address_i[3:0] == OFS_BUF && avs_byteenable_i[0];
	assign wd      = imr_ctrl_t'(avs_writedata_i[7:0]);
	assign fin     = cnt_r == 9'h000;
	// The transmitter of a bit is us for data bits when sending, for the ack bit when receiving.
	assign i_send  = (bit_r < LAST_BIT) ? !rx_r : rx_r;

	function automatic logic pull_low(input logic [3:0] b, input logic rx,
			input logic [7:0] sh, input logic ack);
		if (b < LAST_BIT)
			pull_low = rx ? 1'b0 : !sh[7];
		else
			pull_low = rx ? ack : 1'b0;
	endfunction

	// Pins cross from the bus; the first flop feeds only the second.
	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			scl_m_r <= 1'b1;
			scl_s_r <= 1'b1;
			scl_d_r <= 1'b1;
			sda_m_r <= 1'b1;
			sda_s_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else begin
			scl_m_r <= scl_i;
			scl_s_r <= scl_m_r;
			scl_d_r <= scl_s_r;
			sda_m_r <= sda_i;
			sda_s_r <= sda_m_r;
			sda_d_r <= sda_s_r;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			busy_r <= 1'b0;
		end else if (scl_s_r && scl_d_r && sda_d_r && !sda_s_r) begin
			busy_r <= 1'b1;
		end else if (scl_s_r && scl_d_r && !sda_d_r && sda_s_r) begin
			busy_r <= 1'b0;
		end
	end

	// Half an SCL period; the reserved code falls back to the code 0 factor of 256.
	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			half_r <= DIV_CODE0[9:1];
		end else begin
			case ({ctrl_r.cr2, ctrl_r.cr1, ctrl_r.cr0}) // see R15 see R20
				3'h1:    half_r <= DIV_CODE1[9:1];
				3'h2:    half_r <= DIV_CODE2[9:1];
				3'h3:    half_r <= DIV_CODE3[9:1];
				3'h4:    half_r <= DIV_CODE4[9:1];
				3'h5:    half_r <= DIV_CODE5[9:1];
				3'h6:    half_r <= DIV_CODE6[9:1];
				default: half_r <= DIV_CODE0[9:1];
			endcase
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			wait_r  <= 1'b1;
			rdata_r <= 32'h0000_0000;
		end else begin
			wait_r <= !acc;
			if (avs_read_i && acc) begin
				case (avs_address_i[3:0])
					OFS_CTRL:  rdata_r <= {24'h00_0000, ctrl_r};
					OFS_STATE: rdata_r <= {24'h00_0000, state_code_r};
					OFS_BUF:   rdata_r <= {24'h00_0000, byte_buffer_r}; // see R10
					default:   rdata_r <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Software writes come first so that hardware setting the service flag wins.
	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			ctrl_r        <= imr_ctrl_t'(CTRL_RST);
			byte_buffer_r <= BUF_RST;
			state_code_r  <= ST_NO_INFO;
			st_r          <= S_IDLE;
			ph_r          <= PH_LOW;
			sh_r          <= 8'h00;
			bit_r         <= 4'h0;
			cnt_r         <= 9'h000;
			rx_r          <= 1'b0;
			addr_r        <= 1'b0;
			rd_r          <= 1'b0;
			ack_sel_r     <= 1'b0;
			ack_in_r      <= 1'b1;
			rep_r         <= 1'b0;
			scl_oe_r      <= 1'b0;
			sda_oe_r      <= 1'b0;
			mtx_r         <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				ctrl_r.cr2 <= wd.cr2;
				ctrl_r.ens <= wd.ens;
				ctrl_r.start_request_flag <= wd.start_request_flag;
				ctrl_r.aa  <= wd.aa;
				ctrl_r.cr1 <= wd.cr1;
				ctrl_r.cr0 <= wd.cr0;
				if (wd.stop_request_flag)
					ctrl_r.stop_request_flag <= 1'b1;
				if (!wd.si)
					ctrl_r.si <= 1'b0;
			end
			if (wr_buf)
				byte_buffer_r <= avs_writedata_i[7:0];
			if (!fin)
				cnt_r <= cnt_r - 9'h001;
			if (!ctrl_r.ens) begin
				// Disabled: lines released, state kept for when it is enabled again.
				scl_oe_r <= 1'b0;
				sda_oe_r <= 1'b0;
			end else begin
				case (st_r)
					S_IDLE: begin
						scl_oe_r <= 1'b0; // see R14
						sda_oe_r <= 1'b0;
						if (ctrl_r.start_request_flag && !ctrl_r.si && !busy_r && scl_s_r && sda_s_r) begin
							st_r     <= S_START; // see R1
							sda_oe_r <= 1'b1;
							cnt_r    <= half_r;
							rep_r    <= 1'b0;
						end
					end
					S_START: begin
						if (fin) begin
							scl_oe_r     <= 1'b1;
							state_code_r <= rep_r ? ST_RSTART : ST_START; // see R3 see R4
							ctrl_r.si    <= 1'b1; // see R21
							st_r         <= S_HOLD;
						end
					end
					S_HOLD: begin
						scl_oe_r <= 1'b1;
						sda_oe_r <= 1'b0;
						if (!ctrl_r.si) begin
							case (state_code_r)
								ST_START, ST_RSTART: begin
									st_r     <= S_BITS; // see R3
									ph_r     <= PH_LOW;
									bit_r    <= 4'h0;
									cnt_r    <= half_r;
									sh_r     <= byte_buffer_r;
									rd_r     <= byte_buffer_r[0];
									addr_r   <= 1'b1;
									rx_r     <= 1'b0;
									sda_oe_r <= !byte_buffer_r[7];
								end
								ST_AR_ACK, ST_RX_ACK: begin
									st_r      <= S_BITS; // see R6 see R2
									ph_r      <= PH_LOW;
									bit_r     <= 4'h0;
									cnt_r     <= half_r;
									addr_r    <= 1'b0;
									rx_r      <= 1'b1;
									ack_sel_r <= ctrl_r.aa;
								end
								default: begin
									if (ctrl_r.stop_request_flag) begin
										st_r     <= S_STOP; // see R8 see R9
										ph_r     <= PH_LOW;
										cnt_r    <= half_r;
										sda_oe_r <= 1'b1;
									end else if (ctrl_r.start_request_flag) begin
										st_r  <= S_RST; // see R7
										ph_r  <= PH_LOW;
										cnt_r <= half_r;
									end
								end
							endcase
						end
					end
					S_BITS, S_STOP, S_RST: begin
						case (ph_r)
							PH_LOW: begin
								if (fin) begin
									scl_oe_r <= 1'b0; // see R22
									ph_r     <= PH_WAIT;
								end
							end
							PH_WAIT: begin
								// A stretched or foreign low keeps us here, see R16.
								if (scl_s_r) begin
									ph_r  <= PH_HIGH;
									cnt_r <= half_r;
									if (st_r == S_BITS) begin
										if (bit_r < LAST_BIT)
											sh_r <= {sh_r[6:0], sda_s_r};
										else
											ack_in_r <= sda_s_r;
										if (i_send && !sda_oe_r && !sda_s_r) begin
											st_r         <= S_LOSTW; // see R11 see R12 see R13
											scl_oe_r     <= 1'b0;
											sda_oe_r     <= 1'b0;
											state_code_r <= ST_LOST; // see R5
											ctrl_r.si    <= 1'b1;
											mtx_r        <= 1'b0;
										end
									end
								end
							end
							PH_HIGH: begin
								if (st_r == S_BITS && scl_s_r && scl_d_r && sda_s_r != sda_d_r) begin
									st_r         <= S_BERR; // see R17
									scl_oe_r     <= 1'b0;
									sda_oe_r     <= 1'b0;
									state_code_r <= ST_BERR;
									ctrl_r.si    <= 1'b1;
								end else if (fin || !scl_s_r) begin
									// Another master pulling SCL low ends our high period early.
									scl_oe_r <= 1'b1;
									ph_r     <= PH_LOW;
									cnt_r    <= half_r;
									case (st_r)
										S_BITS: begin
											if (bit_r == LAST_BIT) begin
												st_r      <= S_HOLD;
												sda_oe_r  <= 1'b0;
												ctrl_r.si <= 1'b1; // see R21
												if (addr_r && rd_r)
													state_code_r <= ack_in_r ? ST_AR_NACK : ST_AR_ACK; // see R2
												else if (addr_r) begin
													state_code_r <= ack_in_r ? ST_AW_NACK : ST_AW_ACK;
													mtx_r        <= 1'b1; // see R4
												end else begin
													byte_buffer_r <= sh_r;
													state_code_r  <= ack_sel_r ? ST_RX_ACK : ST_RX_NACK; // see R6
												end
											end else begin
												bit_r    <= bit_r + 4'h1;
												sda_oe_r <= pull_low(bit_r + 4'h1, rx_r, sh_r, ack_sel_r);
											end
										end
										S_STOP: begin
											scl_oe_r     <= 1'b0;
											sda_oe_r     <= 1'b0;
											ctrl_r.stop_request_flag   <= wr_ctrl && wd.stop_request_flag; // see R8
											state_code_r <= ST_NO_INFO;
											mtx_r        <= 1'b0;
											st_r         <= S_IDLE; // see R9
										end
										default: begin
											scl_oe_r <= 1'b0;
											sda_oe_r <= 1'b1;
											rep_r    <= 1'b1;
											st_r     <= S_START; // see R7
										end
									endcase
								end
							end
							default: ph_r <= PH_LOW;
						endcase
					end
					S_LOSTW: begin
						scl_oe_r <= 1'b0;
						sda_oe_r <= 1'b0;
						if (!ctrl_r.si) begin
							state_code_r <= ST_NO_INFO;
							st_r         <= S_IDLE; // see R5
						end
					end
					S_BERR: begin
						scl_oe_r <= 1'b0; // see R19
						sda_oe_r <= 1'b0;
						if (ctrl_r.stop_request_flag && !ctrl_r.si) begin
							ctrl_r.stop_request_flag   <= wr_ctrl && wd.stop_request_flag; // see R18
							state_code_r <= ST_NO_INFO;
							mtx_r        <= 1'b0;
							st_r         <= S_IDLE;
						end
					end
					default: st_r <= S_IDLE;
				endcase
			end
		end
	end

	assign avs_readdata_o         = rdata_r;
	assign avs_waitrequest_o      = wait_r;
	assign scl_o                  = 1'b0;
	assign sda_o                  = 1'b0;
	assign scl_oe_o               = scl_oe_r;
	assign sda_oe_o               = sda_oe_r;
	assign master_transmit_mode_o = mtx_r;

	a_start_code: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // see R3
		(st_r == S_START && fin && ctrl_r.ens) |=>
			(state_code_r == ST_START || state_code_r == ST_RSTART) && ctrl_r.si && scl_oe_r)
		else $error("START not reported with service flag");

	a_addr_read: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // see R2
		(st_r == S_BITS && ph_r == PH_HIGH && fin && bit_r == LAST_BIT && addr_r && rd_r
			&& ctrl_r.ens && !(scl_s_r && scl_d_r && sda_s_r != sda_d_r)) |=>
			(state_code_r == ST_AR_ACK || state_code_r == ST_AR_NACK) && ctrl_r.si)
		else $error("read address end not reported");

	a_rx_ack: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // see R6
		(st_r == S_BITS && rx_r && bit_r == LAST_BIT && ph_r == PH_WAIT) |-> sda_oe_r == ack_sel_r)
		else $error("ack bit does not follow ack-assert");

	a_lost_code: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // see R5
		(st_r == S_BITS && ph_r == PH_WAIT && scl_s_r && i_send && !sda_oe_r && !sda_s_r
			&& ctrl_r.ens) |=> st_r == S_LOSTW && state_code_r == ST_LOST ##1 !sda_oe_r && !scl_oe_r)
		else $error("arbitration loss not handled");

	a_berr_code: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // see R17
		(st_r == S_BITS && ph_r == PH_HIGH && scl_s_r && scl_d_r && sda_s_r != sda_d_r
			&& ctrl_r.ens) |=> state_code_r == ST_BERR && ctrl_r.si && !scl_oe_r)
		else $error("bus error not reported");

	a_berr_exit: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // see R18
		(st_r == S_BERR && ctrl_r.stop_request_flag && !ctrl_r.si && ctrl_r.ens && !wr_ctrl) |=>
			st_r == S_IDLE && !ctrl_r.stop_request_flag && !sda_oe_r && !scl_oe_r)
		else $error("bus error exit wrong");

	a_stop_clear: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // see R8
		(st_r == S_STOP && ph_r == PH_HIGH && fin && ctrl_r.ens && !wr_ctrl) |=>
			!ctrl_r.stop_request_flag && !sda_oe_r && st_r == S_IDLE)
		else $error("stop request not cleared after STOP");

	a_sync_wait: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // see R16
		(ph_r == PH_WAIT && !scl_s_r && st_r == S_BITS) |=> ph_r == PH_WAIT && !scl_oe_r)
		else $error("high period timed before SCL release");

	a_idle_quiet: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // see R14
		(st_r == S_IDLE && $past(st_r) == S_IDLE) |-> !scl_oe_r)
		else $error("clock driven outside master mode");

	a_rate_pick: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // see R20
		({ctrl_r.cr2, ctrl_r.cr1, ctrl_r.cr0} == 3'h4) |=> half_r == DIV_CODE4[9:1])
		else $error("clock rate factor wrong");

endmodule

// ==== verification/imr_slave_model.sv ====
// Purpose: Behavioural slave on the two-wire bus for the receiver bench.
// Assumes: Pull-ups on both lines; one master at a time addresses it.
// Notes:   Stretching holds SCL after every falling edge of a transfer it is active in, while requested.
`timescale 1ns/1ps
module imr_slave_model #(
	parameter logic [6:0] DEV_ADDR = 7'h2a
) (
	input  wire logic       clk_i,
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	input  wire logic       stretch_i,
	input  wire logic [7:0] tx_byte_i,
	output logic            sda_oe_o,
	output logic            scl_oe_o
);
	logic       scl_q = 1'b1, sda_q = 1'b1, act = 1'b0, dat = 1'b0, aack = 1'b0, mack = 1'b0;
	logic [3:0] cnt = 4'h0, bi = 4'h8;
	logic [7:0] sh = 8'h00, hold = 8'h00;
	// Data follows the byte input live, so the bench may change it while SCL is held low.
	assign sda_oe_o = aack | (dat && bi < 4'h8 && !tx_byte_i[3'h7 - bi[2:0]]);
	assign scl_oe_o = hold != 8'h00;
	always @(posedge clk_i) begin
		scl_q <= scl_i;
		sda_q <= sda_i;
		if (hold != 8'h00) hold <= hold - 8'h01;
		if (scl_i && scl_q && sda_q != sda_i) begin
			act <= !sda_i;
			dat <= 1'b0;
			aack <= 1'b0;
			cnt <= 4'h0;
			bi <= 4'h8;
		end else if (act && scl_i && !scl_q) begin
			if (cnt < 4'h8) sh <= {sh[6:0], sda_i};
			mack <= !sda_i;
			cnt <= cnt + 4'h1;
		end else if (act && !scl_i && scl_q) begin
			hold <= stretch_i ? 8'h64 : 8'h00;
			bi <= cnt;
			if (cnt == 4'h8 && !dat) aack <= (sh[7:1] == DEV_ADDR);
			if (cnt == 4'h9) begin
				cnt <= 4'h0;
				bi <= 4'h0;
				aack <= 1'b0;
				dat <= dat ? mack : (aack && sh[0]);
				act <= dat ? mack : aack;
			end
		end
	end
endmodule

// ==== verification/imr_master_rx_test.sv ====
// Purpose: Self-checking bench for the two-wire master receiver.
// Assumes: One slave model and a rival pull on SDA, pull-ups on both lines.
// Notes:   The service flag is polled; the block has no interrupt line.
`timescale 1ns/1ps
module imr_master_rx_test;
	import imr_pkg::*;
	localparam logic [6:0] DEV = 7'h2a;
	localparam logic [2:0] RATES [4] = '{3'h6, 3'h5, 3'h3, 3'h7};
	localparam logic [9:0] DIVS [4] = '{DIV_CODE6, DIV_CODE5, DIV_CODE3, DIV_CODE0};
	logic        clk_sys_i = 1'b0, rstn_i = 1'b0, rd = 1'b0, wr = 1'b0;
	logic        stretch = 1'b0, rival = 1'b0, mon_clr = 1'b1;
	logic [3:0]  adr = 4'h0;
	logic [31:0] wdata = 32'h0, rdata, q;
	logic        wreq, scl_oe, sda_oe, s_scl, s_sda, mtx, sda_hit, scl_lvl, sda_lvl;
	logic [7:0]  tx = 8'h01, seed = 8'h01;
	logic [2:0]  rate = 3'h6;
	logic [9:0]  lo_run = 10'h0, hi_run = 10'h0, lo_min, hi_min;
	int          num_errors = 0, n_compared = 0;
	wire logic   scl_ln = !(scl_oe | s_scl);
	wire logic   sda_ln = !(sda_oe | s_sda | rival);
	imr_master_rx i_imr_master_rx (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .avs_address_i(adr),
		.avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(4'h1),
		.avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .scl_i(scl_ln), .scl_o(scl_lvl),
		.scl_oe_o(scl_oe), .sda_i(sda_ln), .sda_o(sda_lvl), .sda_oe_o(sda_oe),
		.master_transmit_mode_o(mtx));
	imr_slave_model #(.DEV_ADDR(DEV)) i_imr_slave_model (.clk_i(clk_sys_i), .scl_i(scl_ln),
		.sda_i(sda_ln), .stretch_i(stretch), .tx_byte_i(tx), .sda_oe_o(s_sda), .scl_oe_o(s_scl));
	always #4 clk_sys_i = !clk_sys_i;
	// Runs saturate so that a long idle or a held clock cannot wrap into a false minimum.
	always @(posedge clk_sys_i) begin
		lo_run <= scl_oe ? lo_run + {9'h0, lo_run != 10'h3ff} : 10'h0;
		hi_run <= scl_ln ? hi_run + {9'h0, hi_run != 10'h3ff} : 10'h0;
		if (mon_clr) begin
			lo_min <= 10'h3ff;
			hi_min <= 10'h3ff;
			sda_hit <= 1'b0;
		end else begin
			if (!scl_oe && lo_run != 10'h0 && lo_run < lo_min) lo_min <= lo_run;
			if (!scl_ln && hi_run != 10'h0 && hi_run < hi_min) hi_min <= hi_run;
			sda_hit <= sda_hit | sda_oe;
		end
	end
	function automatic logic [7:0] lfsr(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	function automatic logic [7:0] cw(input logic start_request_flag, input logic stop_request_flag, input logic aa);
		return {rate[2], 1'b1, start_request_flag, stop_request_flag, 1'b0, aa, rate[1:0]};
	endfunction
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
		int n;
		n = 0;
		adr <= a;
		wdata <= {24'h0, d};
		wr <= w;
		rd <= !w;
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (wreq !== 1'b0 && n < 50);
		if (n >= 50) num_errors++;
		q = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
		@(posedge clk_sys_i);
	endtask
	task automatic wait_st(input logic [7:0] exp);
		int n;
		n = 0;
		do begin
			acc(1'b0, exp == ST_NO_INFO ? OFS_STATE : OFS_CTRL, 8'h00);
			n++;
		end while ((exp == ST_NO_INFO ? q[7:0] !== exp : q[3] !== 1'b1) && n < 2000);
		acc(1'b0, OFS_STATE, 8'h00);
		chk("state_code", q, {24'h0, exp});
		acc(1'b0, OFS_CTRL, 8'h00);
		chk("service_flag", q[3], exp != ST_NO_INFO);
	endtask
	task automatic send_addr(input logic [7:0] a, input logic [7:0] exp);
		acc(1'b1, OFS_BUF, a);
		acc(1'b1, OFS_CTRL, cw(1'b0, 1'b0, 1'b1));
		wait_st(exp);
	endtask
	task automatic recv(input int n);
		for (int k = 0; k < n; k++) begin
			seed = lfsr(seed);
			tx <= seed;
			acc(1'b1, OFS_CTRL, cw(1'b0, 1'b0, k < n - 1));
			wait_st(k < n - 1 ? ST_RX_ACK : ST_RX_NACK);
			acc(1'b0, OFS_BUF, 8'h00);
			chk("byte_buffer", q, {24'h0, seed});
		end
	endtask
	task automatic stop_test;
		$display("compared %0d errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		repeat (90000) @(posedge clk_sys_i);
		num_errors++;
		stop_test;
	end
	initial begin
		repeat (2) @(posedge clk_sys_i);
		rstn_i <= 1'b1;
		@(posedge clk_sys_i);
		for (int i = 0; i < 4; i++) begin
			acc(1'b0, 4'(i * 4), 8'h00);
			chk("reset_read", q, i == 1 ? 32'hf8 : 32'h0);
		end
		for (int i = 0; i < 4; i++) begin
			rate = RATES[i];
			stretch <= (i == 1);
			mon_clr <= 1'b1;
			acc(1'b1, OFS_CTRL, cw(1'b1, 1'b0, 1'b1));
			mon_clr <= 1'b0;
			wait_st(ST_START);
			send_addr({DEV, 1'b1}, ST_AR_ACK);
			recv(3);
			acc(1'b1, OFS_CTRL, cw(1'b1, 1'b1, 1'b1));
			wait_st(ST_START);
			chk("stop_request_flag", q[4], 1'b0);
			send_addr({~DEV, 1'b1}, ST_AR_NACK);
			acc(1'b1, OFS_CTRL, cw(1'b0, 1'b1, 1'b1));
			wait_st(ST_NO_INFO);
			chk("stop_request_flag", q[4], 1'b0);
			chk("scl_low_run", lo_min >= DIVS[i] / 2 && lo_min <= DIVS[i] / 2 + 2, 1'b1);
			chk("scl_high_run", hi_min >= DIVS[i] / 2, 1'b1);
		end
		rate = 3'h6;
		stretch <= 1'b0;
		acc(1'b1, OFS_CTRL, cw(1'b1, 1'b0, 1'b1));
		wait_st(ST_START);
		send_addr({DEV, 1'b1}, ST_AR_ACK);
		recv(1);
		acc(1'b1, OFS_CTRL, cw(1'b1, 1'b0, 1'b0));
		wait_st(ST_RSTART);
		send_addr({DEV, 1'b0}, ST_AW_ACK);
		chk("master_transmit_mode", mtx, 1'b1);
		acc(1'b1, OFS_CTRL, cw(1'b0, 1'b1, 1'b0));
		wait_st(ST_NO_INFO);
		// A rival holding SDA low beats our second address bit, which is a one.
		acc(1'b1, OFS_CTRL, cw(1'b1, 1'b0, 1'b1));
		wait_st(ST_START);
		acc(1'b1, OFS_BUF, {DEV, 1'b1});
		acc(1'b1, OFS_CTRL, cw(1'b0, 1'b0, 1'b1));
		rival <= 1'b1;
		wait_st(ST_LOST);
		chk("line_pulls", {scl_oe, sda_oe}, 2'b00);
		chk("drive_levels", {scl_lvl, sda_lvl}, 2'b00);
		rival <= 1'b0;
		acc(1'b1, OFS_CTRL, cw(1'b0, 1'b0, 1'b1));
		wait_st(ST_NO_INFO);
		acc(1'b1, OFS_CTRL, cw(1'b1, 1'b0, 1'b1));
		wait_st(ST_START);
		send_addr({DEV, 1'b1}, ST_AR_ACK);
		tx <= 8'hff;
		acc(1'b1, OFS_CTRL, cw(1'b0, 1'b0, 1'b1));
		for (int n = 0; n < 1000 && scl_ln !== 1'b1; n++) @(posedge clk_sys_i);
		rival <= 1'b1;
		wait_st(ST_BERR);
		rival <= 1'b0;
		mon_clr <= 1'b1;
		acc(1'b1, OFS_CTRL, cw(1'b0, 1'b1, 1'b0));
		mon_clr <= 1'b0;
		wait_st(ST_NO_INFO);
		chk("stop_request_flag", q[4], 1'b0);
		chk("pulled_after_error", sda_hit | scl_oe, 1'b0);
		stop_test;
	end
endmodule
